// >>> swi_device.sv
// device end of the single-wire link: response fifo, bit receiver and sequencer
// Function
// - host waits 100us, then 60us wake low
// - device initialised within 400us after wake
// - host waits 1500us after wake before data
// - host sends only wake until initialised
// - active inputs ignore pulses under 45ns
// - sleeping ignores low pulses under 60us
// - watchdog forces sleep unless disabled
// - host pulses 4.34us, one character per bit
// - bit symbols match seven-bit no-parity UART
// - host bits 39us apart, within timeout
// - response starts 64 to 131us after flag
// - host waits 93us after device last bit
// - link stalled mid-byte or mid-command past timeout sleeps
// - flags select command, transmit, idle, sleep
// - every legal bit restarts link timeout
// - link timeout disabled while executing
// - watchdog stopped in idle mode
`timescale 1ns/10ps
`default_nettype none

module swi_fifo #(
   parameter int WIDTH = swi_pkg::BYTE_W,
   parameter int DEPTH = swi_pkg::FIFO_DEPTH
) (
   input  wire logic             clk,
   input  wire logic             rstn,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wp;
      logic [AW-1:0]               rp;
      logic [AW:0]                 cnt;
      logic                        rdy;
      logic                        vld;
   } fifo_type;
   fifo_type s_r;
   fifo_type s_nxt;
   logic     push;
   logic     pop;
   // pointers wrap at depth; ready and valid follow the next count
   always_comb begin
      s_nxt = s_r;
      push  = in_valid && s_r.rdy;
      pop   = out_ready && s_r.vld;
      if (push) begin
         s_nxt.mem[s_r.wp] = in_data;
         s_nxt.wp          = (s_r.wp == AW'(DEPTH - 1)) ? '0 : s_r.wp + 1'b1;
      end
      if (pop) begin
         s_nxt.rp = (s_r.rp == AW'(DEPTH - 1)) ? '0 : s_r.rp + 1'b1;
      end
      s_nxt.cnt = s_r.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
      s_nxt.rdy = s_nxt.cnt != (AW + 1)'(DEPTH);
      s_nxt.vld = s_nxt.cnt != '0;
   end
   always_ff @(posedge clk) begin
      if (!rstn) begin
         s_r     <= '0;
         s_r.rdy <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end
   assign in_ready  = s_r.rdy;
   assign out_valid = s_r.vld;
   assign out_data  = s_r.mem[s_r.rp];
endmodule // swi_fifo

module swi_bit_rx #(
   parameter int WIN = swi_pkg::ZERO_WIN_CYC
) (
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic       clr,
   input  wire logic       line,
   output logic            fall,
   output logic            bit_done,
   output logic            active,
   output logic            byte_valid,
   output logic [7:0]      byte_data
);
   typedef struct packed {
      logic        prev;
      logic        inbit;
      logic        zero;
      logic [11:0] cnt;
      logic [7:0]  sh;
      logic [2:0]  nb;
      logic        fall;
      logic        bitv;
      logic        bv;
   } rx_type;
   rx_type s_r;
   rx_type s_nxt;
   // a start fall opens a window; a second fall inside it makes a zero
   always_comb begin
      s_nxt      = s_r;
      s_nxt.prev = line;
      s_nxt.fall = s_r.prev && !line;
      s_nxt.bitv = 1'b0;
      s_nxt.bv   = 1'b0;
      if (clr) begin
         s_nxt.inbit = 1'b0;
         s_nxt.nb    = '0;
         s_nxt.fall  = 1'b0;
      end else if (s_r.inbit) begin
         s_nxt.cnt = s_r.cnt + 1'b1;
         if (s_nxt.fall) begin
            s_nxt.zero = 1'b1;
         end
         if (s_r.cnt == 12'(WIN - 1)) begin
            s_nxt.inbit = 1'b0;
            s_nxt.sh    = {!s_r.zero, s_r.sh[7:1]};   // lsb first
            s_nxt.nb    = s_r.nb + 1'b1;
            s_nxt.bitv  = 1'b1;
            s_nxt.bv    = s_r.nb == 3'h7;
         end
      end else if (s_nxt.fall) begin
         s_nxt.inbit = 1'b1;
         s_nxt.cnt   = '0;
         s_nxt.zero  = 1'b0;
      end
   end
   always_ff @(posedge clk) begin
      if (!rstn) begin
         s_r      <= '0;
         s_r.prev <= swi_pkg::LINE_IDLE;
      end else begin
         s_r <= s_nxt;
      end
   end
   assign fall       = s_r.fall;
   assign bit_done   = s_r.bitv;
   assign active     = s_r.inbit || (s_r.nb != '0);
   assign byte_valid = s_r.bv;
   assign byte_data  = s_r.sh;
endmodule // swi_bit_rx

module swi_device #(
   parameter int WAKE_LOW_CYC = swi_pkg::WAKE_LOW_CYC,
   parameter int INIT_CYC     = swi_pkg::INIT_CYC,
   parameter int WDOG_CYC     = swi_pkg::WDOG_CYC,
   parameter int TOUT_CYC     = swi_pkg::TOUT_CYC,
   parameter int TURN_CYC     = swi_pkg::TURN_CYC,
   parameter int DBIT_CYC     = swi_pkg::DBIT_CYC,
   parameter int FIFO_DEPTH   = swi_pkg::FIFO_DEPTH
) (
   input  wire logic       CLK,
   input  wire logic       RSTN,
   swi_link_if.dev         LINK,
   output logic [7:0]      CMD_DATA,
   output logic            CMD_VALID,
   input  wire logic       EXEC_BUSY,
   input  wire logic       WATCHDOG_DISABLE,
   input  wire logic [7:0] RESP_DATA,
   input  wire logic       RESP_VALID,
   output logic            RESP_READY,
   output logic            AWAKE,
   output logic            INIT_DONE
);
   localparam swi_pkg::cnt_type PD = swi_pkg::cnt_type'(swi_pkg::DPULSE_CYC);
   typedef enum logic [8:0] {
      D_SLEEP  = 9'h001,
      D_WAKE   = 9'h002,
      D_INIT   = 9'h004,
      D_ACTIVE = 9'h008,
      D_CMD    = 9'h010,
      D_TURN   = 9'h020,
      D_TX     = 9'h040,
      D_IDLE   = 9'h080,
      D_OFF    = 9'h100
   } dstate_type;
   typedef struct packed {
      dstate_type       st;
      logic             flt;
      logic [2:0]       fcnt;
      swi_pkg::cnt_type tcnt;
      swi_pkg::cnt_type wdog;
      swi_pkg::cnt_type tout;
      swi_pkg::gap_type sfall;
      logic [7:0]       left;
      logic             first;
      logic [7:0]       sh;
      logic [2:0]       nb;
      logic             oe;
      logic             cmdv;
      logic [7:0]       cmdd;
      logic             awake;
      logic             rdy;
   } dev_type;
   dev_type    s_r;
   dev_type    s_nxt;
   logic       pop;
   logic       f_vld;
   logic [7:0] f_data;
   logic       rx_clr;
   logic       rx_fall;
   logic       rx_bit;
   logic       rx_act;
   logic       rx_bv;
   logic [7:0] rx_byte;
   logic       tout_run;

   // response bytes wait here until a transmit flag drains them
   swi_fifo #(.WIDTH(swi_pkg::BYTE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk       (CLK),
      .rstn      (RSTN),
      .in_valid  (RESP_VALID),
      .in_ready  (RESP_READY),
      .in_data   (RESP_DATA),
      .out_valid (f_vld),
      .out_ready (pop),
      .out_data  (f_data)
   );
   // receiver only listens while waiting for flags or command bytes
   assign rx_clr   = !(s_r.st == D_ACTIVE || s_r.st == D_CMD) || EXEC_BUSY;
   assign tout_run = (s_r.st == D_CMD || (s_r.st == D_ACTIVE && rx_act)) && !EXEC_BUSY;
   swi_bit_rx #(.WIN(swi_pkg::ZERO_WIN_CYC)) u_rx (
      .clk        (CLK),
      .rstn       (RSTN),
      .clr        (rx_clr),
      .line       (s_r.flt),
      .fall       (rx_fall),
      .bit_done   (rx_bit),
      .active     (rx_act),
      .byte_valid (rx_bv),
      .byte_data  (rx_byte)
   );

   // sequencer: wake, init, flag decode, command bytes, turnaround, response
   always_comb begin
      s_nxt      = s_r;
      s_nxt.cmdv = 1'b0;
      pop        = 1'b0;
      if (LINK.line != s_r.flt) begin
         s_nxt.fcnt = s_r.fcnt + 1'b1;
         if (s_r.fcnt == 3'(swi_pkg::GLITCH_CYC - 1)) begin
            s_nxt.flt  = LINK.line;
            s_nxt.fcnt = '0;
         end
      end else begin
         s_nxt.fcnt = '0;
      end
      s_nxt.tout = (rx_bit || !tout_run) ? '0 : s_r.tout + 1'b1;
      if (rx_fall) begin
         s_nxt.sfall = '0;
      end else if (s_r.sfall != '1) begin
         s_nxt.sfall = s_r.sfall + 1'b1;
      end
      unique case (s_r.st)
         D_SLEEP, D_IDLE: begin
            // short lows restart the count and never wake
            s_nxt.tcnt = LINK.line ? '0 : s_r.tcnt + 1'b1;
            if (!LINK.line && s_r.tcnt == swi_pkg::cnt_type'(WAKE_LOW_CYC - 1)) begin
               s_nxt.st = D_WAKE;
            end
         end
         D_WAKE: begin
            if (LINK.line) begin
               s_nxt.st   = D_INIT;
               s_nxt.tcnt = '0;
            end
         end
         D_INIT: begin
            s_nxt.tcnt = s_r.tcnt + 1'b1;
            if (s_r.tcnt == swi_pkg::cnt_type'(INIT_CYC - 1)) begin
               s_nxt.st  = D_ACTIVE;
               s_nxt.flt = swi_pkg::LINE_IDLE;
            end
         end
         D_ACTIVE: begin
            if (rx_bv) begin
               // reserved values are dropped
               case (rx_byte)
                  swi_pkg::FLAG_CMD: begin
                     s_nxt.st    = D_CMD;
                     s_nxt.first = 1'b1;
                  end
                  swi_pkg::FLAG_TX:    s_nxt.st = D_TURN;
                  swi_pkg::FLAG_IDLE:  s_nxt.st = D_IDLE;
                  swi_pkg::FLAG_SLEEP: s_nxt.st = D_SLEEP;
                  default:             s_nxt.st = D_ACTIVE;
               endcase
            end
         end
         D_CMD: begin
            // first byte is the group length, itself included
            if (rx_bv) begin
               s_nxt.cmdv  = 1'b1;
               s_nxt.cmdd  = rx_byte;
               s_nxt.first = 1'b0;
               s_nxt.left  = s_r.first ? rx_byte - 1'b1 : s_r.left - 1'b1;
               if (s_r.first ? (rx_byte <= 8'h01) : (s_r.left <= 8'h01)) begin
                  s_nxt.st = D_ACTIVE;
               end
            end
         end
         D_TURN: begin
            if (s_r.sfall >= swi_pkg::gap_type'(TURN_CYC)) begin
               s_nxt.tcnt = '0;
               s_nxt.nb   = '0;
               s_nxt.sh   = f_data;
               pop        = f_vld;
               s_nxt.st   = f_vld ? D_TX : D_ACTIVE;
            end
         end
         D_TX: begin
            s_nxt.tcnt = s_r.tcnt + 1'b1;
            if (s_r.tcnt == swi_pkg::cnt_type'(DBIT_CYC - 1)) begin
               s_nxt.tcnt = '0;
               s_nxt.nb   = s_r.nb + 1'b1;
               s_nxt.sh   = {1'b0, s_r.sh[7:1]};
               if (s_r.nb == 3'h7) begin
                  s_nxt.sh = f_data;
                  pop      = f_vld;
                  s_nxt.st = f_vld ? D_TX : D_ACTIVE;
               end
            end
         end
         default: s_nxt.st = D_SLEEP;
      endcase
      if (tout_run && s_r.tout == swi_pkg::cnt_type'(TOUT_CYC - 1)) begin
         s_nxt.st = D_SLEEP;
      end
      // watchdog runs from wake, holds in idle, fires unless disabled
      if (s_r.st == D_SLEEP || s_r.st == D_WAKE) begin
         s_nxt.wdog = '0;
      end else if (s_r.st != D_IDLE) begin
         s_nxt.wdog = s_r.wdog + 1'b1;
         if (!WATCHDOG_DISABLE && s_r.wdog == swi_pkg::cnt_type'(WDOG_CYC - 1)) begin
            s_nxt.st = D_SLEEP;
         end
      end
      // one bit = start low, and for a zero a high then a second low
      s_nxt.oe    = s_nxt.st == D_TX && (s_nxt.tcnt < PD ||
                    (!s_nxt.sh[0] && s_nxt.tcnt >= 2 * PD && s_nxt.tcnt < 3 * PD));
      s_nxt.awake = !(s_nxt.st == D_SLEEP || s_nxt.st == D_WAKE);
      s_nxt.rdy   = s_nxt.st == D_ACTIVE || s_nxt.st == D_CMD || s_nxt.st == D_TURN || s_nxt.st == D_TX;
   end
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         s_r     <= '0;
         s_r.st  <= D_SLEEP;
         s_r.flt <= swi_pkg::LINE_IDLE;
      end else begin
         s_r <= s_nxt;
      end
   end
   assign LINK.dev_drv = 1'b0;   // open drain: only ever pulls low
   assign LINK.dev_oe  = s_r.oe;
   assign CMD_DATA     = s_r.cmdd;
   assign CMD_VALID    = s_r.cmdv;
   assign AWAKE        = s_r.awake;
   assign INIT_DONE    = s_r.rdy;
endmodule // swi_device
`default_nettype wire

// >>> swi_pkg.sv
// shared timing, flag and width constants for the single-wire link
package swi_pkg;
   localparam int CLK_NS        = 8;
   localparam int PWRUP_NS      = 100_000;
   localparam int PWRUP_CYC     = (PWRUP_NS + CLK_NS - 1) / CLK_NS;
   localparam int WAKE_LOW_NS   = 60_000;
   localparam int WAKE_LOW_CYC  = (WAKE_LOW_NS + CLK_NS - 1) / CLK_NS;
   localparam int INIT_NS       = 400_000;
   localparam int INIT_CYC      = INIT_NS / CLK_NS;
   localparam int WAKE_HI_NS    = 1_500_000;
   localparam int WAKE_HI_CYC   = (WAKE_HI_NS + CLK_NS - 1) / CLK_NS;
   localparam int GLITCH_NS     = 45;
   localparam int GLITCH_CYC    = (GLITCH_NS + CLK_NS - 1) / CLK_NS;
   localparam int WDOG_NS       = 1_300_000_000;
   localparam int WDOG_CYC      = WDOG_NS / CLK_NS;
   localparam int TOUT_NS       = 65_000_000;
   localparam int TOUT_CYC      = TOUT_NS / CLK_NS;
   localparam int HPULSE_NS     = 4_340;
   localparam int HPULSE_CYC    = HPULSE_NS / CLK_NS;
   localparam int HBIT_NS       = 39_000;
   localparam int HBIT_CYC      = (HBIT_NS + CLK_NS - 1) / CLK_NS;
   localparam int DPULSE_NS     = 6_000;
   localparam int DPULSE_CYC    = DPULSE_NS / CLK_NS;
   localparam int DBIT_NS       = 54_000;
   localparam int DBIT_CYC      = DBIT_NS / CLK_NS;
   localparam int TURN_NS       = 96_000;
   localparam int TURN_CYC      = TURN_NS / CLK_NS;
   localparam int HREV_NS       = 93_000;
   localparam int HREV_CYC      = (HREV_NS + CLK_NS - 1) / CLK_NS;
   localparam int ZERO_WIN_NS   = 20_000;
   localparam int ZERO_WIN_CYC  = ZERO_WIN_NS / CLK_NS;
   localparam int BYTE_W        = 8;
   localparam int FIFO_DEPTH    = 32;
   localparam logic [7:0] FLAG_CMD   = 8'h77;
   localparam logic [7:0] FLAG_TX    = 8'h88;
   localparam logic [7:0] FLAG_IDLE  = 8'hBB;
   localparam logic [7:0] FLAG_SLEEP = 8'hCC;
   localparam logic       LINE_IDLE  = 1'b1;
   typedef logic [27:0] cnt_type;
   typedef logic [13:0] gap_type;
endpackage

// >>> swi_link_if.sv
// open-drain single data line joining host end and device end
`timescale 1ns/10ps
`default_nettype none
interface swi_link_if;
   logic host_drv;
   logic host_oe;
   logic dev_drv;
   logic dev_oe;
   logic line;
   // wire is low while either enabled end drives a zero
   assign line = !((host_oe && !host_drv) || (dev_oe && !dev_drv));
   modport dev  (input line, output dev_drv, output dev_oe);
   modport host (input line, output host_drv, output host_oe);
endinterface
`default_nettype wire

// >>> swi_host.sv
// host end of the single-wire link: power-up wait, wake pulse and byte sender
`timescale 1ns/10ps
`default_nettype none
module swi_host #(
   parameter int PWRUP_CYC    = swi_pkg::PWRUP_CYC,
   parameter int WAKE_LOW_CYC = swi_pkg::WAKE_LOW_CYC,
   parameter int WAKE_HI_CYC  = swi_pkg::WAKE_HI_CYC,
   parameter int HBIT_CYC     = swi_pkg::HBIT_CYC,
   parameter int HREV_CYC     = swi_pkg::HREV_CYC
) (
   input  wire logic       CLK,
   input  wire logic       RSTN,
   swi_link_if.host        LINK,
   input  wire logic       WAKE_REQ,
   input  wire logic [7:0] TX_DATA,
   input  wire logic       TX_VALID,
   output logic            TX_READY,
   output logic [7:0]      RX_DATA,
   output logic            RX_VALID,
   output logic            LINK_READY
);
   localparam swi_pkg::cnt_type PH = swi_pkg::cnt_type'(swi_pkg::HPULSE_CYC);
   typedef enum logic [5:0] {
      H_PWRUP = 6'h01,
      H_OFF   = 6'h02,
      H_WLOW  = 6'h04,
      H_WHIGH = 6'h08,
      H_RDY   = 6'h10,
      H_SEND  = 6'h20
   } hstate_type;
   typedef struct packed {
      hstate_type       st;
      swi_pkg::cnt_type tcnt;
      swi_pkg::gap_type sfall;
      logic [7:0]       sh;
      logic [2:0]       nb;
      logic             oe;
      logic             trdy;
      logic             lrdy;
   } host_type;
   host_type s_r;
   host_type s_nxt;
   logic     rx_clr;
   logic     rx_fall;

   // listen for response bits only while ready, not in power-up, off, waking or sending
   assign rx_clr = s_r.st != H_RDY;
   swi_bit_rx #(.WIN(swi_pkg::ZERO_WIN_CYC)) u_rx (
      .clk        (CLK),
      .rstn       (RSTN),
      .clr        (rx_clr),
      .line       (LINK.line),
      .fall       (rx_fall),
      .bit_done   (),
      .active     (),
      .byte_valid (RX_VALID),
      .byte_data  (RX_DATA)
   );

   // sequencer: power-up wait, wake low, wake high wait, bit sending
   always_comb begin
      s_nxt = s_r;
      if (rx_fall) begin
         s_nxt.sfall = '0;
      end else if (s_r.sfall != '1) begin
         s_nxt.sfall = s_r.sfall + 1'b1;
      end
      unique case (s_r.st)
         H_PWRUP: begin
            s_nxt.tcnt = s_r.tcnt + 1'b1;
            if (s_r.tcnt == swi_pkg::cnt_type'(PWRUP_CYC - 1)) begin
               s_nxt.st = H_OFF;
            end
         end
         H_OFF: begin
            if (WAKE_REQ) begin
               s_nxt.st   = H_WLOW;
               s_nxt.tcnt = '0;
            end
         end
         H_WLOW: begin
            s_nxt.tcnt = s_r.tcnt + 1'b1;
            if (s_r.tcnt == swi_pkg::cnt_type'(WAKE_LOW_CYC - 1)) begin
               s_nxt.st   = H_WHIGH;
               s_nxt.tcnt = '0;
            end
         end
         H_WHIGH: begin
            // line left high, nothing sent until WAKE_HI_CYC cycles have passed
            s_nxt.tcnt = s_r.tcnt + 1'b1;
            if (s_r.tcnt == swi_pkg::cnt_type'(WAKE_HI_CYC - 1)) begin
               s_nxt.st = H_RDY;
            end
         end
         H_RDY: begin
            if (WAKE_REQ) begin
               s_nxt.st   = H_WLOW;
               s_nxt.tcnt = '0;
            end else if (TX_VALID && s_r.trdy) begin
               s_nxt.st   = H_SEND;
               s_nxt.sh   = TX_DATA;   // flags and command bytes alike
               s_nxt.nb   = '0;
               s_nxt.tcnt = '0;
            end
         end
         H_SEND: begin
            s_nxt.tcnt = s_r.tcnt + 1'b1;
            if (s_r.tcnt == swi_pkg::cnt_type'(HBIT_CYC - 1)) begin
               s_nxt.tcnt = '0;
               s_nxt.nb   = s_r.nb + 1'b1;
               s_nxt.sh   = {1'b0, s_r.sh[7:1]};   // lsb first
               if (s_r.nb == 3'h7) begin
                  s_nxt.st = H_RDY;
               end
            end
         end
         default: s_nxt.st = H_PWRUP;
      endcase
      // start low, and for a zero a high then low, each one pulse wide
      s_nxt.oe   = s_nxt.st == H_WLOW || (s_nxt.st == H_SEND && (s_nxt.tcnt < PH ||
                   (!s_nxt.sh[0] && s_nxt.tcnt >= 2 * PH && s_nxt.tcnt < 3 * PH)));
      s_nxt.trdy = s_nxt.st == H_RDY && !WAKE_REQ &&
                   s_nxt.sfall >= swi_pkg::gap_type'(HREV_CYC);
      s_nxt.lrdy = s_nxt.st == H_RDY || s_nxt.st == H_SEND;
   end
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         s_r       <= '0;
         s_r.st    <= H_PWRUP;
         s_r.sfall <= '1;
      end else begin
         s_r <= s_nxt;
      end
   end
   assign LINK.host_drv = 1'b0;   // open drain: only ever pulls low
   assign LINK.host_oe  = s_r.oe;
   assign TX_READY      = s_r.trdy;
   assign LINK_READY    = s_r.lrdy;
endmodule // swi_host
`default_nettype wire

// >>> swi_link_monitor.sv
// checker for pulse widths, bit spacing and turnaround on the single-wire link
`timescale 1ns/10ps
`default_nettype none
module swi_link_monitor #(
   parameter int WAKE_LOW_CYC = swi_pkg::WAKE_LOW_CYC,
   parameter int HBIT_CYC     = swi_pkg::HBIT_CYC,
   parameter int DBIT_CYC     = swi_pkg::DBIT_CYC,
   parameter int TURN_CYC     = swi_pkg::TURN_CYC,
   parameter int HREV_CYC     = swi_pkg::HREV_CYC
) (
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic host_drv,
   input wire logic host_oe,
   input wire logic dev_drv,
   input wire logic dev_oe,
   input wire logic line
);
   typedef struct packed {
      logic [15:0] hw;
      logic [15:0] dw;
      logic [15:0] hg;
      logic [15:0] dg;
      logic        seen;
      logic        ph;
      logic        pd;
   } mon_type;
   mon_type mon_r;
   mon_type mon_nxt;
   // low widths, cycles since the last bit start, and whether a reply has begun
   always_comb begin
      mon_nxt = mon_r;
      mon_nxt.ph = host_oe;
      mon_nxt.pd = dev_oe;
      mon_nxt.hw = host_oe ? mon_r.hw + 16'h0001 : 16'h0000;
      mon_nxt.dw = dev_oe ? mon_r.dw + 16'h0001 : 16'h0000;
      mon_nxt.hg = (mon_r.hg == 16'hFFFF) ? mon_r.hg : mon_r.hg + 16'h0001;
      mon_nxt.dg = (mon_r.dg == 16'hFFFF) ? mon_r.dg : mon_r.dg + 16'h0001;
      if (host_oe && !mon_r.ph && mon_r.hg > 16'h05DC) begin
         mon_nxt.hg = 16'h0001;
      end
      if (!host_oe && mon_r.ph && mon_r.hw == WAKE_LOW_CYC) begin
         mon_nxt.hg = 16'hFFFF; // next host low after a wake is a bit start
      end
      if (dev_oe && !mon_r.pd && mon_r.dg > 16'h07D0) begin
         mon_nxt.dg = 16'h0001;
      end
      if (dev_oe && !mon_r.pd) begin
         mon_nxt.seen = 1'b1;
      end else if (host_oe && !mon_r.ph) begin
         mon_nxt.seen = 1'b0;
      end
   end
   // register the tracking state
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         mon_r <= '1;
      end else begin
         mon_r <= mon_nxt;
      end
   end
   default clocking @(posedge CLK); endclocking
   default disable iff (!RSTN);
   sequence s_host_start;
      $rose(host_oe) && mon_r.hg > 16'h05DC;
   endsequence
   sequence s_first_reply;
      $rose(dev_oe) && !mon_r.seen;
   endsequence
   sequence s_dev_next;
      $rose(dev_oe) && mon_r.seen && mon_r.dg > 16'h07D0;
   endsequence
   a_quiet_after_reset: assert property ($rose(RSTN) |-> (!host_oe && !dev_oe) [*8])
      else $error("link driven right after reset");
   a_host_pulse_width: assert property ($fell(host_oe) |-> mon_r.hw == swi_pkg::HPULSE_CYC || mon_r.hw == WAKE_LOW_CYC)
      else $error("host low pulse has wrong width");
   a_dev_pulse_width: assert property ($fell(dev_oe) |-> mon_r.dw == swi_pkg::DPULSE_CYC)
      else $error("device low pulse has wrong width");
   a_host_zero_shape: assert property ($rose(host_oe) && mon_r.hg <= 16'h05DC |-> mon_r.hg == 2 * swi_pkg::HPULSE_CYC)
      else $error("host zero second low misplaced");
   a_host_bit_spacing: assert property (s_host_start |-> mon_r.hg >= HBIT_CYC)
      else $error("host bits too close");
   a_dev_bit_spacing: assert property (s_dev_next |-> mon_r.dg == DBIT_CYC)
      else $error("device bit period wrong");
   a_reply_delay: assert property (s_first_reply |-> mon_r.hg inside {[TURN_CYC:TURN_CYC + 40]})
      else $error("reply start outside turnaround");
   a_host_reversal: assert property ($rose(host_oe) && mon_r.seen |-> mon_r.dg >= HREV_CYC)
      else $error("host restarted too soon after reply");
   a_no_collision: assert property (dev_oe |-> !host_oe)
      else $error("both ends drive the line");
endmodule // swi_link_monitor
`default_nettype wire

// >>> secure_element_wake_swi_timing_tb_top.sv
// testbench joining host and device ends through the link interface
`timescale 1ns/10ps
`default_nettype none
module secure_element_wake_swi_timing_tb_top;
   localparam int WAKE_LOW = 200, HBIT = 2600, DBIT = 3000, TURN = 4000, HREV = 3000, WDOG = 3000;
   typedef struct packed {
      logic [7:0] flag;
      logic       reply;
      logic       awake;
      logic       init;
   } row_type;
   row_type    rows [3] = '{'{8'h88, 1'b1, 1'b1, 1'b1}, '{8'hBB, 1'b0, 1'b1, 1'b0}, '{8'hCC, 1'b0, 1'b0, 1'b0}};
   logic       clk, rstn = 1'b0, wake_req = 1'b0, tx_valid = 1'b0, resp_valid = 1'b0, wdog_disable = 1'b1;
   logic       exec_busy = 1'b0;
   logic [7:0] tx_data = 8'h00, resp_data = 8'h00, rx_data, cmd_data;
   logic       tx_ready, rx_valid, link_ready, cmd_valid, resp_ready, awake, init_done;
   int         fails = 0, total_checks = 0, cycles = 0, n;
   swi_link_if swi_link_if_inst ();
   swi_device #(.WAKE_LOW_CYC(WAKE_LOW), .INIT_CYC(300), .WDOG_CYC(WDOG), .TOUT_CYC(20000), .TURN_CYC(TURN),
      .DBIT_CYC(DBIT), .FIFO_DEPTH(32)) swi_device_inst (.CLK(clk), .RSTN(rstn), .LINK(swi_link_if_inst),
      .CMD_DATA(cmd_data), .CMD_VALID(cmd_valid), .EXEC_BUSY(exec_busy), .WATCHDOG_DISABLE(wdog_disable),
      .RESP_DATA(resp_data), .RESP_VALID(resp_valid), .RESP_READY(resp_ready), .AWAKE(awake), .INIT_DONE(init_done));
   swi_host #(.PWRUP_CYC(20), .WAKE_LOW_CYC(WAKE_LOW), .WAKE_HI_CYC(400), .HBIT_CYC(HBIT), .HREV_CYC(HREV))
      swi_host_inst (.CLK(clk), .RSTN(rstn), .LINK(swi_link_if_inst), .WAKE_REQ(wake_req), .TX_DATA(tx_data),
      .TX_VALID(tx_valid), .TX_READY(tx_ready), .RX_DATA(rx_data), .RX_VALID(rx_valid), .LINK_READY(link_ready));
   swi_link_monitor #(.WAKE_LOW_CYC(WAKE_LOW), .HBIT_CYC(HBIT), .DBIT_CYC(DBIT), .TURN_CYC(TURN), .HREV_CYC(HREV))
      swi_link_monitor_inst (.CLK(clk), .RSTN(rstn), .host_drv(swi_link_if_inst.host_drv),
      .host_oe(swi_link_if_inst.host_oe), .dev_drv(swi_link_if_inst.dev_drv), .dev_oe(swi_link_if_inst.dev_oe),
      .line(swi_link_if_inst.line));
   // free-running clock and hang guard
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 120000) begin
         fails++;
         end_of_test();
      end
   end
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic end_of_test();
      if (fails == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   function automatic logic pick(input int sel);
      case (sel)
         0: return tx_ready;
         1: return rx_valid;
         default: return link_ready;
      endcase
   endfunction
   // wait for a handshake or status flag under a bound
   task automatic wait_hi(input int sel, input int lim);
      int k;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pick(sel) !== 1'b1 && k < lim);
      check("handshake", 16'(pick(sel)), 16'h0001);
   endtask
   task automatic do_reset(input int cyc);
      rstn <= 1'b0;
      repeat (cyc) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      check("reset_outs", 16'({resp_ready, awake, init_done, link_ready, tx_ready}), 16'h0010);
      repeat (30) @(posedge clk);
   endtask
   task automatic wake();
      wake_req <= 1'b1;
      @(posedge clk);
      wake_req <= 1'b0;
      repeat (2) @(posedge clk);
      wait_hi(2, 2000);
      check("init_after_wake", 16'({awake, init_done}), 16'h0003);
   endtask
   task automatic send(input logic [7:0] b);
      tx_data <= b;
      tx_valid <= 1'b1;
      wait_hi(0, 20000);
      tx_valid <= 1'b0;
      repeat (2) @(posedge clk);
      wait_hi(0, 30000);
   endtask
   // flags from the table, then watchdog, mid-wake reset and fifo limits
   initial begin
      do_reset(20);
      resp_data <= 8'hA5;
      resp_valid <= 1'b1;
      @(posedge clk);
      resp_valid <= 1'b0;
      for (int i = 0; i < 3; i++) begin
         if (init_done !== 1'b1) begin
            wake();
         end
         send(rows[i].flag);
         if (rows[i].reply) begin
            wait_hi(1, 40000);
            check("reply_byte", 16'(rx_data), 16'h00A5);
         end
         repeat (1000) @(posedge clk);
         check("awake_init", 16'({awake, init_done}), 16'({rows[i].awake, rows[i].init}));
      end
      wdog_disable <= 1'b0;
      wake();
      exec_busy <= 1'b1;
      n = 0;
      while (awake === 1'b1 && n < 4000) begin
         @(posedge clk);
         n++;
      end
      check("watchdog_span", 16'(n >= 2300 && n <= WDOG), 16'h0001);
      exec_busy <= 1'b0;
      wake_req <= 1'b1;
      repeat (100) @(posedge clk);
      wake_req <= 1'b0;
      do_reset(3);
      // response fifo filled through the device port until it refuses
      resp_valid <= 1'b1;
      n = 0;
      repeat (40) begin
         @(posedge clk);
         if (resp_ready === 1'b1) begin
            n++;
            resp_data <= 8'(n);
         end
      end
      resp_valid <= 1'b0;
      check("fifo_fill", 16'({resp_ready, 8'(n)}), 16'h0020);
      end_of_test();
   end
endmodule // secure_element_wake_swi_timing_tb_top
`default_nettype wire
